// *** core/tpw_timer_pwm.sv ***
// 16-bit timer in fast and phase correct pwm modes with axi4-lite registers
// Summary of operation
// - single slope counts up to top: fixed 8/9/10 bit, capture or compare a
// - single slope: after matching top the count returns to zero, counts up
// - single slope: overflow flag at top, plus compare a or capture flag
// - each channel flag sets whenever count equals its compare value
// - fixed top: compare writes store zeros above the resolution
// - capture top is unbuffered; written below count, counter wraps at max
// - compare writes go to a buffer, loaded at top in single slope
// - single slope: setting 2 clears on match, sets at top-bottom; 3 reverse
// - compare level drives the pin only while its direction selects output
// - single slope: compare zero gives a spike, compare top a constant
// - mode 15 with action 1 toggles output a on each match
// - modes 1, 2, 3, 10, 11 count up to top and back down
// - dual slope top: fixed 8/9/10 bit, capture or compare a
// - dual slope: count stays at top one timer cycle, then counts down
// - dual slope: overflow flag sets at bottom
// - dual slope: buffers load at top, with compare a or capture flag
// - dual slope: setting 2 clears on up match, sets on down; 3 reverse
// - dual slope: compare bottom holds low, compare top holds high
// - mode 11 with action 1 toggles output a for 50% duty
// - action setting 0 leaves the output state unchanged on matches
// - nonzero action replaces the port value; direction bit keeps the enable
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_timer_pwm (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic timer_tick,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic compare_a_output_pin,
    output logic compare_a_output_oe,
    output logic compare_b_output_pin,
    output logic compare_b_output_oe
);
    import tpw_pkg::*;

    tpw_main_t s_q;
    tpw_main_t s_d;
    logic reg_wr;
    logic [7:0] reg_wr_addr;
    logic [31:0] reg_wr_data;
    logic [3:0] reg_wr_strb;
    logic [31:0] reg_rd_data;
    logic [3:0] waveform_mode_sel;
    logic [1:0] output_a_action_sel;
    logic [1:0] output_b_action_sel;
    logic single_slope;
    logic dual_slope;
    logic fixed_top;
    logic top_is_cap;
    logic top_is_cmp_a;
    logic [15:0] top_value;
    logic [15:0] write_mask;
    logic at_top;
    logic eff_up;
    logic tick_run;
    logic wr_a;
    logic wr_b;
    logic clr_a;
    logic clr_b;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [15:0] compare_a_value;
    logic [15:0] compare_b_value;
    logic out_a;
    logic out_b;
    logic flag_a;
    logic flag_b;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    tpw_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .reg_wr(reg_wr),
        .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data),
        .reg_wr_strb(reg_wr_strb),
        .reg_rd_data(reg_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode decode and top selection
    assign waveform_mode_sel = s_q.ctrl[`TPW_CTRL_MODE];
    assign output_a_action_sel = s_q.ctrl[`TPW_CTRL_ACT_A];
    assign output_b_action_sel = s_q.ctrl[`TPW_CTRL_ACT_B];

    always_comb begin
        single_slope = 1'b0;
        dual_slope = 1'b0;
        fixed_top = 1'b0;
        top_is_cap = 1'b0;
        top_is_cmp_a = 1'b0;
        top_value = `TPW_MAX;
        case (waveform_mode_sel)
            `TPW_MODE_FP8, `TPW_MODE_FP9, `TPW_MODE_FP10,
            `TPW_MODE_FP_CAP, `TPW_MODE_FP_CMPA: single_slope = 1'b1;
            `TPW_MODE_PC8, `TPW_MODE_PC9, `TPW_MODE_PC10,
            `TPW_MODE_PC_CAP, `TPW_MODE_PC_CMPA: dual_slope = 1'b1;
            default: single_slope = 1'b0;
        endcase
        case (waveform_mode_sel)
            `TPW_MODE_FP8, `TPW_MODE_PC8: begin
                top_value = `TPW_TOP_8;
                fixed_top = 1'b1;
            end
            `TPW_MODE_FP9, `TPW_MODE_PC9: begin
                top_value = `TPW_TOP_9;
                fixed_top = 1'b1;
            end
            `TPW_MODE_FP10, `TPW_MODE_PC10: begin
                top_value = `TPW_TOP_10;
                fixed_top = 1'b1;
            end
            `TPW_MODE_FP_CAP, `TPW_MODE_PC_CAP: begin
                top_value = s_q.capture;
                top_is_cap = 1'b1;
            end
            `TPW_MODE_FP_CMPA, `TPW_MODE_PC_CMPA: begin
                top_value = compare_a_value;
                top_is_cmp_a = 1'b1;
            end
            default: top_value = `TPW_MAX;
        endcase
    end

    // fixed top masks compare writes above the resolution
    assign write_mask = fixed_top ? top_value : `TPW_MAX;
    assign at_top = (s_q.count == top_value);
    assign tick_run = timer_tick && (single_slope || dual_slope);
    // in dual slope the turning points count as the following slope
    assign eff_up = (s_q.dir == TPW_UP) ? !at_top
                                        : (s_q.count == `TPW_BOTTOM);
    assign wr_a = reg_wr && (reg_wr_addr == `TPW_OFF_CMP_A);
    assign wr_b = reg_wr && (reg_wr_addr == `TPW_OFF_CMP_B);
    assign clr_a = reg_wr && (reg_wr_addr == `TPW_OFF_FLAGS)
                   && reg_wr_strb[0] && reg_wr_data[`TPW_FLAG_CMP_A];
    assign clr_b = reg_wr && (reg_wr_addr == `TPW_OFF_FLAGS)
                   && reg_wr_strb[0] && reg_wr_data[`TPW_FLAG_CMP_B];

    ////////////////////////////////////////////////////////////////////////
    // compare channels; only channel a can toggle, and only with it as top
    tpw_compare_unit u_cmp_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_run),
        .count(s_q.count),
        .eff_up(eff_up),
        .single_slope(single_slope),
        .at_top(at_top),
        .toggle_en(top_is_cmp_a),
        .action_sel(output_a_action_sel),
        .wr_en(wr_a),
        .wr_data(merge16(cmp_a_buf, reg_wr_data, reg_wr_strb) & write_mask),
        .flag_clr(clr_a),
        .buffer_value(cmp_a_buf),
        .active_value(compare_a_value),
        .out_state(out_a),
        .flag(flag_a)
    );

    tpw_compare_unit u_cmp_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_run),
        .count(s_q.count),
        .eff_up(eff_up),
        .single_slope(single_slope),
        .at_top(at_top),
        .toggle_en(1'b0),
        .action_sel(output_b_action_sel),
        .wr_en(wr_b),
        .wr_data(merge16(cmp_b_buf, reg_wr_data, reg_wr_strb) & write_mask),
        .flag_clr(clr_b),
        .buffer_value(cmp_b_buf),
        .active_value(compare_b_value),
        .out_state(out_b),
        .flag(flag_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // counter, flags, register writes and pin drive
    always_comb begin
        s_d = s_q;
        if (tick_run) begin
            if (single_slope) begin
                if (at_top) begin
                    s_d.count = `TPW_BOTTOM;
                end else begin
                    s_d.count = s_q.count + 16'h0001;
                end
            end else if (s_q.dir == TPW_UP) begin
                if (at_top) begin
                    s_d.count = s_q.count - 16'h0001;
                    s_d.dir = TPW_DOWN;
                end else begin
                    s_d.count = s_q.count + 16'h0001;
                end
            end else if (s_q.count == `TPW_BOTTOM) begin
                s_d.count = s_q.count + 16'h0001;
                s_d.dir = TPW_UP;
            end else begin
                s_d.count = s_q.count - 16'h0001;
            end
        end
        if (!single_slope && !dual_slope) begin
            s_d.dir = TPW_UP;
        end
        // register writes, a software count write wins over the tick
        if (reg_wr) begin
            case (reg_wr_addr)
                `TPW_OFF_CTRL: begin
                    if (reg_wr_strb[0]) begin
                        s_d.ctrl[7:0] = reg_wr_data[7:0];
                    end
                    if (reg_wr_strb[1]) begin
                        s_d.ctrl[11:8] = reg_wr_data[11:8];
                    end
                end
                `TPW_OFF_COUNT: s_d.count =
                    merge16(s_q.count, reg_wr_data, reg_wr_strb);
                `TPW_OFF_CAPTURE: s_d.capture =
                    merge16(s_q.capture, reg_wr_data, reg_wr_strb);
                `TPW_OFF_FLAGS: begin
                    if (reg_wr_strb[0] && reg_wr_data[`TPW_FLAG_OVF]) begin
                        s_d.ovf_flag = 1'b0;
                    end
                    if (reg_wr_strb[0] && reg_wr_data[`TPW_FLAG_CAPT]) begin
                        s_d.cap_flag = 1'b0;
                    end
                end
                default: s_d.ctrl = s_d.ctrl;
            endcase
        end
        // flag sets come after the clears so a same-cycle event is kept
        if (tick_run && single_slope && at_top) begin
            s_d.ovf_flag = 1'b1;
        end
        if (tick_run && dual_slope && (s_q.dir == TPW_DOWN)
            && (s_q.count == `TPW_BOTTOM)) begin
            s_d.ovf_flag = 1'b1;
        end
        if (tick_run && at_top && top_is_cap) begin
            s_d.cap_flag = 1'b1;
        end
        // pin value: compare state overrides the port bit, enable by direction
        s_d.pin_a_out = (output_a_action_sel != `TPW_ACT_NONE)
                        ? out_a : s_q.ctrl[`TPW_CTRL_PORT_A];
        s_d.pin_b_out = (output_b_action_sel != `TPW_ACT_NONE)
                        ? out_b : s_q.ctrl[`TPW_CTRL_PORT_B];
        s_d.pin_a_oe = s_q.ctrl[`TPW_CTRL_DIR_A];
        s_d.pin_b_oe = s_q.ctrl[`TPW_CTRL_DIR_B];
    end

    ////////////////////////////////////////////////////////////////////////
    // read data selection
    always_comb begin
        reg_rd_data = 32'h00000000;
        case (s_axi_araddr)
            `TPW_OFF_CTRL: reg_rd_data[11:0] = s_q.ctrl;
            `TPW_OFF_COUNT: reg_rd_data[15:0] = s_q.count;
            `TPW_OFF_CMP_A: reg_rd_data[15:0] = cmp_a_buf;
            `TPW_OFF_CMP_B: reg_rd_data[15:0] = cmp_b_buf;
            `TPW_OFF_CAPTURE: reg_rd_data[15:0] = s_q.capture;
            `TPW_OFF_FLAGS: reg_rd_data[3:0] =
                {s_q.cap_flag, flag_b, flag_a, s_q.ovf_flag};
            `TPW_OFF_STATUS: reg_rd_data[2:0] =
                {out_b, out_a, (s_q.dir == TPW_DOWN)};
            default: reg_rd_data = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // timer state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign compare_a_output_pin = s_q.pin_a_out;
    assign compare_a_output_oe = s_q.pin_a_oe;
    assign compare_b_output_pin = s_q.pin_b_out;
    assign compare_b_output_oe = s_q.pin_b_oe;
endmodule // tpw_timer_pwm

// *** common/tpw_defines.svh ***
// register map, field positions, reset values and mode codes of the timer
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH
`define TPW_ADDR_W 8
`define TPW_OFF_CTRL 8'h00
`define TPW_OFF_COUNT 8'h04
`define TPW_OFF_CMP_A 8'h08
`define TPW_OFF_CMP_B 8'h0C
`define TPW_OFF_CAPTURE 8'h10
`define TPW_OFF_FLAGS 8'h14
`define TPW_OFF_STATUS 8'h18
`define TPW_OFF_LAST 8'h18
// control register fields
`define TPW_CTRL_MODE 3:0
`define TPW_CTRL_ACT_A 5:4
`define TPW_CTRL_ACT_B 7:6
`define TPW_CTRL_DIR_A 8
`define TPW_CTRL_DIR_B 9
`define TPW_CTRL_PORT_A 10
`define TPW_CTRL_PORT_B 11
`define TPW_CTRL_RESET 12'h000
// flag register bits, write one to clear
`define TPW_FLAG_OVF 0
`define TPW_FLAG_CMP_A 1
`define TPW_FLAG_CMP_B 2
`define TPW_FLAG_CAPT 3
// waveform mode codes
`define TPW_MODE_PC8 4'h1
`define TPW_MODE_PC9 4'h2
`define TPW_MODE_PC10 4'h3
`define TPW_MODE_FP8 4'h5
`define TPW_MODE_FP9 4'h6
`define TPW_MODE_FP10 4'h7
`define TPW_MODE_PC_CAP 4'hA
`define TPW_MODE_PC_CMPA 4'hB
`define TPW_MODE_FP_CAP 4'hE
`define TPW_MODE_FP_CMPA 4'hF
// fixed top values, other counter constants, output action codes and bus response codes
`define TPW_TOP_8 16'h00FF
`define TPW_TOP_9 16'h01FF
`define TPW_TOP_10 16'h03FF
`define TPW_MAX 16'hFFFF
`define TPW_BOTTOM 16'h0000
`define TPW_ACT_NONE 2'h0
`define TPW_ACT_TOGGLE 2'h1
`define TPW_ACT_NONINV 2'h2
`define TPW_ACT_INV 2'h3
`define TPW_RESP_OKAY 2'h0
`define TPW_RESP_DECERR 2'h3
`endif

// *** common/tpw_pkg.sv ***
// types shared by the timer pwm modules
package tpw_pkg;
    typedef enum logic {TPW_UP, TPW_DOWN} tpw_dir_t;

    typedef struct packed {
        logic [15:0] buffer;
        logic [15:0] active;
        logic out_state;
        logic flag;
    } tpw_cmp_t;

    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wr;
        logic [7:0] wr_addr;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
    } tpw_axi_t;

    typedef struct packed {
        logic [15:0] count;
        tpw_dir_t dir;
        logic [11:0] ctrl;
        logic [15:0] capture;
        logic ovf_flag;
        logic cap_flag;
        logic pin_a_out;
        logic pin_a_oe;
        logic pin_b_out;
        logic pin_b_oe;
    } tpw_main_t;
endpackage

// *** core/tpw_compare_unit.sv ***
// one compare channel: buffer, active compare, output state and flag
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_compare_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic [15:0] count,
    input wire logic eff_up,
    input wire logic single_slope,
    input wire logic at_top,
    input wire logic toggle_en,
    input wire logic [1:0] action_sel,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic flag_clr,
    output logic [15:0] buffer_value,
    output logic [15:0] active_value,
    output logic out_state,
    output logic flag
);
    import tpw_pkg::*;

    tpw_cmp_t s_q;
    tpw_cmp_t s_d;
    logic match;

    ////////////////////////////////////////////////////////////////////////
    // next state of the channel
    always_comb begin
        s_d = s_q;
        match = tick && (count == s_q.active);
        if (wr_en) begin
            s_d.buffer = wr_data;
        end
        if (tick && at_top) begin
            s_d.active = s_q.buffer;
        end
        if (match) begin
            case (action_sel)
                `TPW_ACT_TOGGLE: begin
                    if (toggle_en) begin
                        s_d.out_state = ~s_q.out_state;
                    end
                end
                `TPW_ACT_NONINV: s_d.out_state = single_slope ? 1'b0 : ~eff_up;
                `TPW_ACT_INV: s_d.out_state = single_slope ? 1'b1 : eff_up;
                default: s_d.out_state = s_q.out_state;
            endcase
        end
        // top to bottom edge beats a match in the same cycle
        if (tick && at_top && single_slope) begin
            if (action_sel == `TPW_ACT_NONINV) begin
                s_d.out_state = 1'b1;
            end else if (action_sel == `TPW_ACT_INV) begin
                s_d.out_state = 1'b0;
            end
        end
        // a match in the clearing cycle still sets the flag
        if (flag_clr) begin
            s_d.flag = 1'b0;
        end
        if (match) begin
            s_d.flag = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign buffer_value = s_q.buffer;
    assign active_value = s_q.active;
    assign out_state = s_q.out_state;
    assign flag = s_q.flag;
endmodule // tpw_compare_unit

// *** core/tpw_axil_slave.sv ***
// axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic reg_wr,
    output logic [7:0] reg_wr_addr,
    output logic [31:0] reg_wr_data,
    output logic [3:0] reg_wr_strb,
    input wire logic [31:0] reg_rd_data
);
    import tpw_pkg::*;

    tpw_axi_t s_q;
    tpw_axi_t s_d;
    logic w_ok;
    logic r_ok;

    ////////////////////////////////////////////////////////////////////////
    // address channels, write commit and responses
    always_comb begin
        s_d = s_q;
        s_d.wr = 1'b0;
        w_ok = (s_q.aw_addr[1:0] == 2'h0) && (s_q.aw_addr <= `TPW_OFF_LAST);
        r_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `TPW_OFF_LAST);
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // both halves held and no response pending: commit the write
        if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
            s_d.wr = w_ok;
            s_d.wr_addr = s_q.aw_addr;
            s_d.wr_data = s_q.w_data;
            s_d.wr_strb = s_q.w_strb;
            s_d.bvalid = 1'b1;
            s_d.bresp = w_ok ? `TPW_RESP_OKAY : `TPW_RESP_DECERR;
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
        end
        s_d.awready = !s_d.aw_full && !s_d.bvalid;
        s_d.wready = !s_d.w_full && !s_d.bvalid;
        // read: data captured at the address handshake
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = r_ok ? reg_rd_data : 32'h00000000;
            s_d.rresp = r_ok ? `TPW_RESP_OKAY : `TPW_RESP_DECERR;
        end
        s_d.arready = !s_d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign reg_wr = s_q.wr;
    assign reg_wr_addr = s_q.wr_addr;
    assign reg_wr_data = s_q.wr_data;
    assign reg_wr_strb = s_q.wr_strb;
endmodule // tpw_axil_slave

// *** sim/tpw_timer_pwm_properties.sv ***
// bus handshake checker bound to the timer pwm top
`timescale 1ns/1ps
module tpw_timer_pwm_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANS: assert property (s_wr |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    AST_B_BUSY: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_RD_ANS: assert property (s_rd |=> s_axi_rvalid)
        else $error("read response late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    AST_RD_DEC: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h18 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits set");
endmodule // tpw_timer_pwm_properties
bind tpw_timer_pwm tpw_timer_pwm_properties i_props (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// *** sim/tpw_pin_load.sv ***
// port pin model with a pull-up while the timer leaves it undriven
`timescale 1ns/1ps
module tpw_pin_load (
    input wire logic pin,
    input wire logic oe,
    output logic level
);
    // the pull-up wins whenever the driver is off
    assign level = oe ? pin : 1'h1;
endmodule // tpw_pin_load

// *** sim/tpw_timer_pwm_tb.sv ***
// self-checking bench for the timer pwm block
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_timer_pwm_tb;
logic aclk = 0, aresetn = 0, tick = 0, awv = 0, wv = 0, bready = 0;
logic arv = 0, rready = 0, awrdy, wrdy, bvalid, arrdy, rvalid;
logic pa, pae, pb, pbe, la, lb;
logic [7:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata, d;
logic [1:0] bresp, rresp, r;
logic [3:0] mds [6] = '{`TPW_MODE_FP8, `TPW_MODE_FP9, `TPW_MODE_FP10,
    `TPW_MODE_PC8, `TPW_MODE_PC9, `TPW_MODE_PC10};
int err_total = 0, total_checks = 0, cyc = 0, top, c, k, dn;
tpw_timer_pwm i_dut (.aclk(aclk), .aresetn(aresetn), .timer_tick(tick),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compare_a_output_pin(pa), .compare_a_output_oe(pae),
    .compare_b_output_pin(pb), .compare_b_output_oe(pbe));
tpw_pin_load i_load_a (.pin(pa), .oe(pae), .level(la));
tpw_pin_load i_load_b (.pin(pb), .oe(pbe), .level(lb));
initial forever #2 aclk = ~aclk;
task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
// write: both halves offered together
task automatic wr(input logic [7:0] a, input logic [31:0] v,
                  output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
        @(posedge aclk);
        if (awrdy) awv <= 1'h0;
        if (wrdy) wv <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h1;
    @(posedge aclk);
    rs = bresp;
    bready <= 1'h0;
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] v,
                  output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'h1;
    do begin
        @(posedge aclk);
        if (arrdy) arv <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
endtask
// one timer tick per call
task automatic step;
    @(posedge aclk);
    tick <= 1'h1;
    @(posedge aclk);
    tick <= 1'h0;
endtask
function automatic logic [31:0] fix_top(input logic [3:0] m);
    return m[1:0] == 2'h1 ? 32'h00FF : m[1:0] == 2'h2 ? 32'h01FF : 32'h03FF;
endfunction
function automatic logic [31:0] exp_count(input int s, input int t, int n);
    int p;
    p = s ? n % (t + 1) : n % (2 * t);
    return (s || p <= t) ? p : 2 * t - p;
endfunction
// hang guard
always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
        err_total++;
        give_verdict();
    end
end
initial begin
    k = $urandom(30);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`TPW_OFF_CTRL, d, r);
    chk(d, 32'h0);
    rd(8'h1C, d, r);
    chk(r, 32'h3);
    wr(8'h20, 32'h0, r);
    chk(r, 32'h3);
    // compare writes masked to the fixed resolution
    foreach (mds[i]) begin
        wr(`TPW_OFF_CTRL, mds[i], r);
        wr(`TPW_OFF_CMP_A, 32'hFFFF, r);
        rd(`TPW_OFF_CMP_A, d, r);
        chk(d, fix_top(mds[i]));
    end
    // top from compare a: single slope first, then dual slope
    for (int s = 1; s >= 0; s--) begin
        top = 3 + $urandom % 7;
        c = $urandom % (top + 1);
        wr(`TPW_OFF_CTRL, 32'h0, r);
        wr(`TPW_OFF_COUNT, 32'h0, r);
        wr(`TPW_OFF_CMP_A, top, r);
        wr(`TPW_OFF_CMP_B, c, r);
        wr(`TPW_OFF_FLAGS, 32'hF, r);
        wr(`TPW_OFF_CTRL, s ? 32'h78F : 32'h78B, r);
        k = 0;
        do begin
            step();
            rd(`TPW_OFF_COUNT, d, r);
            k++;
        end while ((d !== 32'h0 || k <= 20) && k < 40);
        rd(`TPW_OFF_FLAGS, d, r);
        if (s) chk(d & 32'h3, 32'h3);
        for (k = 1; k <= 2 * top + 2; k++) begin
            step();
            rd(`TPW_OFF_COUNT, d, r);
            chk(d, exp_count(s, top, k));
            dn = !s && (k % (2 * top) == 0 || k % (2 * top) > top);
            chk(lb, exp_count(s, top, k) + dn <= c);
        end
        chk({la, pbe}, 32'h3);
    end
    give_verdict();
end
endmodule // tpw_timer_pwm_tb
